/* File: src/grsf_mem.sv */
// triplet store: one word per slot holding x, y and z samples
// assumes: read data lags the read address by one clock edge
`timescale 1ns/1ps
`default_nettype none
module grsf_mem #(
  parameter int AW = 5,
  parameter int DW = 48
) (
  input wire logic clk,
  grsf_mem_if.store mem
);
  // no reset: contents are meaningless until written
  logic [DW-1:0] slot_reg [2**AW];

  // write port
  always_ff @(posedge clk) begin
    if (mem.we) begin
      slot_reg[mem.waddr] <= mem.wdata;
    end
  end

  // registered read port, old data on a same-slot collision
  always_ff @(posedge clk) begin
    mem.rdata <= slot_reg[mem.raddr];
  end
endmodule // grsf_mem
`default_nettype wire

/* File: src/grsf_mem_if.sv */
// carrier between the buffer control logic and its triplet store
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface grsf_mem_if #(
  parameter int AW = 5,
  parameter int DW = 48
);
  logic we; // write strobe for one triplet
  logic [AW-1:0] waddr; // slot being written
  logic [DW-1:0] wdata; // z, y, x packed high to low
  logic [AW-1:0] raddr; // oldest slot
  logic [DW-1:0] rdata; // registered read data

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: src/grsf_pkg.sv */
// types of the rate sample buffer: mode codes and effective behaviour
// assumes: every user writes grsf_pkg::name, nothing is imported
package grsf_pkg;

  // buffer mode field codes
  typedef enum logic [2:0] {
    GRSF_MODE_BYPASS = 3'h0,
    GRSF_MODE_BUFFER = 3'h1,
    GRSF_MODE_STREAM = 3'h2,
    GRSF_MODE_BYP2STR = 3'h3,
    GRSF_MODE_STR2BUF = 3'h4
  } grsf_mode_t;

  // behaviour actually applied after trigger resolution, one-hot
  typedef enum logic [2:0] {
    GRSF_BEH_BYPASS = 3'b001,
    GRSF_BEH_BUFFER = 3'b010,
    GRSF_BEH_STREAM = 3'b100
  } grsf_beh_t;

endpackage

/* File: src/grsf_regs.svh */
// register offsets, field positions, reset values and sizes of the rate sample buffer
// assumes: included by bare name from the buffer top module
`ifndef GRSF_REGS_SVH
`define GRSF_REGS_SVH

// apb byte offsets, one aligned word each
`define GRSF_OFF_CTRL 8'h00
`define GRSF_OFF_PINCFG 8'h04
`define GRSF_OFF_STATUS 8'h08
`define GRSF_OFF_EVT 8'h0C
`define GRSF_OFF_EVTMASK 8'h10
`define GRSF_OFF_OUTX 8'h14
`define GRSF_OFF_OUTY 8'h18
`define GRSF_OFF_OUTZ 8'h1C
`define GRSF_OFF_BURST 8'h20

// buffer control field layout
`define GRSF_CTRL_WTM_LSB 0
`define GRSF_CTRL_WTM_W 5
`define GRSF_CTRL_MODE_LSB 5
`define GRSF_CTRL_MODE_W 3

// event bit positions, shared by status, sticky, mask and pin enables
`define GRSF_EV_WTM 0
`define GRSF_EV_EMPTY 1
`define GRSF_EV_FULL 2
`define GRSF_EV_W 3

// status register: count sits above the three level flags
`define GRSF_STAT_CNT_LSB 3

// reset values
`define GRSF_CTRL_RST 8'h00
`define GRSF_PINCFG_RST 3'h0
`define GRSF_EVTMASK_RST 3'h0

// buffer geometry
`define GRSF_DEPTH 32
`define GRSF_SAMPLE_W 16

`endif

/* File: src/grsf_top.sv */
// rate sample buffer: three 16-bit channels, five modes, apb register access
// assumes: samples and trigger come from logic on pclk; apb master on pclk
`timescale 1ns/1ps
`default_nettype none
`include "grsf_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] thirty-two 16-bit slots per rate channel
// [R2] five modes selected by control field
// [R3] bypass: buffer empty, live sample overwritten
// [R4] buffer mode stops accepting when full
// [R5] host writes bypass to restart collection
// [R6] watermark event when count reaches level
// [R7] stream full: oldest triplet dropped per arrival
// [R8] bypass-to-stream switches on trigger event
// [R9] stream-to-buffer switches on trigger event
// [R10] events enabled to pin, status readable
// [R11] non-bypass output reads return buffered samples
// [R12] reads load oldest triplet, single or burst
// [R13] burst pointer wraps from z to x
// [R14] host sets auto-increment for burst reads; here there is no such setting, the burst window always advances its lane
// [R15] empty and full status track count
// [R16] pop only after whole triplet read
module grsf_top #(
  parameter int DEPTH = `GRSF_DEPTH,
  parameter int SW = `GRSF_SAMPLE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic [SW-1:0] sample_x,
  input wire logic [SW-1:0] sample_y,
  input wire logic [SW-1:0] sample_z,
  input wire logic trigger_event,
  output logic ready_event_pin,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // resolve mode plus trigger history into the behaviour applied now
  function automatic grsf_pkg::grsf_beh_t beh_of(input grsf_pkg::grsf_mode_t m,
                                                 input logic trig);
    case (m)
      grsf_pkg::GRSF_MODE_BUFFER: beh_of = grsf_pkg::GRSF_BEH_BUFFER;
      grsf_pkg::GRSF_MODE_STREAM: beh_of = grsf_pkg::GRSF_BEH_STREAM;
      grsf_pkg::GRSF_MODE_BYP2STR:
        beh_of = trig ? grsf_pkg::GRSF_BEH_STREAM : grsf_pkg::GRSF_BEH_BYPASS;
      grsf_pkg::GRSF_MODE_STR2BUF:
        beh_of = trig ? grsf_pkg::GRSF_BEH_BUFFER : grsf_pkg::GRSF_BEH_STREAM;
      default: beh_of = grsf_pkg::GRSF_BEH_BYPASS; // unused codes act as bypass
    endcase
  endfunction

  // 16-bit sample picked from a packed triplet, 0 x, 1 y, 2 z
  function automatic logic [SW-1:0] lane(input logic [3*SW-1:0] t, input logic [1:0] i);
    case (i)
      2'h1: lane = t[2*SW-1:SW];
      2'h2: lane = t[3*SW-1:2*SW];
      default: lane = t[SW-1:0];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ctrl_reg, ctrl_next; // mode and watermark level
  logic [2:0] pincfg_reg, pincfg_next; // pin enables per event
  logic [2:0] evt_reg, evt_next; // sticky events, write one clears
  logic [2:0] evtmask_reg, evtmask_next; // interrupt mask
  logic [2:0] lvl_reg, lvl_next; // previous event levels for edges
  logic trig_reg, trig_next; // trigger seen since last control write
  logic [1:0] burst_reg, burst_next; // burst lane pointer
  logic [AW-1:0] wr_reg, wr_next; // next free slot
  logic [AW-1:0] rd_reg, rd_next; // oldest slot
  logic [CW-1:0] cnt_reg, cnt_next; // stored triplets
  logic [3*SW-1:0] live_reg, live_next; // bypass sample slot
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, irq_next, pin_next;

  grsf_mem_if #(.AW(AW), .DW(3*SW)) mem_bus ();

  grsf_mem #(.AW(AW), .DW(3*SW)) u_mem (
    .clk(pclk),
    .mem(mem_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  grsf_pkg::grsf_mode_t mode;
  grsf_pkg::grsf_beh_t beh;
  logic [4:0] wtm_level; // watermark_level field
  logic acc, setup_done, wr_acc, rd_acc, hit, pop, push, drop;
  logic full, empty, wtm;
  logic [2:0] lvl;
  logic [1:0] lane_sel;

  always_comb begin
    mode = grsf_pkg::grsf_mode_t'(ctrl_reg[`GRSF_CTRL_MODE_LSB +: `GRSF_CTRL_MODE_W]);
    wtm_level = ctrl_reg[`GRSF_CTRL_WTM_LSB +: `GRSF_CTRL_WTM_W];
    beh = beh_of(mode, trig_reg); // [R2] [R8] [R9]
    // one wait state: pready rises in the second access cycle
    setup_done = psel & penable & ~pready;
    acc = psel & penable & pready;
    wr_acc = acc & pwrite;
    rd_acc = acc & ~pwrite;
    full = (cnt_reg == FULL_CNT); // [R15]
    empty = (cnt_reg == '0); // [R15]
    wtm = (cnt_reg >= {1'b0, wtm_level}); // [R6]
    lvl = '0;
    lvl[`GRSF_EV_WTM] = wtm;
    lvl[`GRSF_EV_EMPTY] = empty;
    lvl[`GRSF_EV_FULL] = full;
    // pop only when z, the last lane of the triplet, is consumed
    pop = rd_acc & ~empty & (beh != grsf_pkg::GRSF_BEH_BYPASS) &
          ((paddr == `GRSF_OFF_OUTZ) | ((paddr == `GRSF_OFF_BURST) & (burst_reg == 2'h2))); // [R16]
    push = sample_valid & (beh != grsf_pkg::GRSF_BEH_BYPASS) &
           ((beh == grsf_pkg::GRSF_BEH_STREAM) | ~full); // [R4]
    drop = push & full & ~pop; // [R7]
    lane_sel = burst_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer pointers and count
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    trig_next = trig_reg | trigger_event; // [R8] [R9]
    live_next = sample_valid ? {sample_z, sample_y, sample_x} : live_reg; // [R3]
    if (beh == grsf_pkg::GRSF_BEH_BYPASS) begin
      // bypass holds the buffer empty; also the restart path after a fill
      wr_next = '0; // [R3] [R5]
      rd_next = '0;
      cnt_next = '0;
    end else begin
      if (push) begin
        wr_next = wr_reg + AW'(1);
      end
      if (pop | drop) begin
        rd_next = rd_reg + AW'(1); // [R7] [R16]
      end
      if (push & ~pop & ~full) begin
        cnt_next = cnt_reg + CW'(1); // [R1]
      end else if (pop & ~push) begin
        cnt_next = cnt_reg - CW'(1);
      end
    end
    // a control write restarts trigger tracking; a trigger in that cycle is lost
    if (wr_acc & (paddr == `GRSF_OFF_CTRL)) begin
      trig_next = 1'b0;
    end
  end

  // memory drive; the read port looks one step ahead so that its registered
  // data already shows the new oldest slot in the cycle after a pop or drop
  always_comb begin
    mem_bus.we = push;
    mem_bus.waddr = wr_reg;
    mem_bus.wdata = {sample_z, sample_y, sample_x};
    mem_bus.raddr = rd_next; // [R12]
  end

  // pointer registers; the reset branch loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      trig_reg <= 1'b0;
      live_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      trig_reg <= trig_next;
      live_reg <= live_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb registers, events and outputs
  always_comb begin
    ctrl_next = ctrl_reg;
    pincfg_next = pincfg_reg;
    evtmask_next = evtmask_reg;
    burst_next = burst_reg;
    evt_next = evt_reg;
    lvl_next = lvl;
    pready_next = setup_done;
    pslverr_next = 1'b0;
    prdata_next = prdata;
    hit = 1'b1;
    // software writes: write-one-clear on sticky events
    if (wr_acc) begin
      case (paddr)
        `GRSF_OFF_CTRL: ctrl_next = pwdata[7:0]; // [R2] [R5]
        `GRSF_OFF_PINCFG: pincfg_next = pwdata[2:0];
        `GRSF_OFF_EVTMASK: evtmask_next = pwdata[2:0];
        `GRSF_OFF_EVT: evt_next = evt_reg & ~pwdata[2:0];
        default: ;
      endcase
    end
    // new edges set after the clear so a same-cycle event survives
    evt_next = evt_next | (lvl & ~lvl_reg); // [R6] [R10]
    // burst lane advance, wrap z back to x
    if (rd_acc & (paddr == `GRSF_OFF_BURST)) begin
      burst_next = (burst_reg == 2'h2) ? 2'h0 : burst_reg + 2'h1; // [R13]
    end
    // read data prepared in the first access cycle
    if (setup_done) begin
      prdata_next = '0;
      case (paddr)
        `GRSF_OFF_CTRL: prdata_next = {24'h0, ctrl_reg};
        `GRSF_OFF_PINCFG: prdata_next = {29'h0, pincfg_reg};
        `GRSF_OFF_STATUS: prdata_next = {23'h0, cnt_reg, lvl}; // [R10] [R15]
        `GRSF_OFF_EVT: prdata_next = {29'h0, evt_reg};
        `GRSF_OFF_EVTMASK: prdata_next = {29'h0, evtmask_reg};
        `GRSF_OFF_OUTX, `GRSF_OFF_OUTY, `GRSF_OFF_OUTZ: begin
          // bypass shows the live slot, other modes the oldest triplet
          prdata_next = {16'h0, lane(beh == grsf_pkg::GRSF_BEH_BYPASS ? live_reg :
                                     mem_bus.rdata, paddr[3:2] + 2'h3)}; // [R11] [R12]
        end
        `GRSF_OFF_BURST: begin
          prdata_next = {16'h0, lane(beh == grsf_pkg::GRSF_BEH_BYPASS ? live_reg :
                                     mem_bus.rdata, lane_sel)}; // [R12] [R13]
        end
        default: hit = 1'b0;
      endcase
      pslverr_next = ~hit; // unmapped offsets answer with an error
    end
    irq_next = |(evt_next & evtmask_next);
    pin_next = |(lvl & pincfg_reg); // [R10]
  end

  // register stage; every top-level output leaves straight from a flop here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `GRSF_CTRL_RST;
      pincfg_reg <= `GRSF_PINCFG_RST;
      evtmask_reg <= `GRSF_EVTMASK_RST;
      evt_reg <= '0;
      lvl_reg <= '0;
      burst_reg <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      ready_event_pin <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      pincfg_reg <= pincfg_next;
      evtmask_reg <= evtmask_next;
      evt_reg <= evt_next;
      lvl_reg <= lvl_next;
      burst_reg <= burst_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      irq <= irq_next;
      ready_event_pin <= pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks; they watch design state and apb, sample and trigger inputs, and stay quiet during reset
  sequence seq_full_arrival;
    full && sample_valid && !pop;
  endsequence

  sequence seq_z_read;
    pop && !push;
  endsequence

  chk_count_bound: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    cnt_reg <= FULL_CNT) else $error("count above depth");

  chk_bypass_empty: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (beh == grsf_pkg::GRSF_BEH_BYPASS) |-> !mem_bus.we ##1 (cnt_reg == '0))
    else $error("bypass left data in buffer");

  chk_buffer_stop: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (beh == grsf_pkg::GRSF_BEH_BUFFER) and seq_full_arrival |-> !mem_bus.we ##1 full)
    else $error("buffer accepted sample when full");

  chk_wtm_event: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    $rose(wtm) |=> evt_reg[`GRSF_EV_WTM]) else $error("watermark event missed");

  chk_stream_drop: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (beh == grsf_pkg::GRSF_BEH_STREAM) and seq_full_arrival |=>
      full && (rd_reg == $past(rd_reg) + AW'(1))) else $error("oldest not dropped");

  chk_trig_stream: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    (mode == grsf_pkg::GRSF_MODE_BYP2STR) && trigger_event && !wr_acc |=>
      (beh == grsf_pkg::GRSF_BEH_STREAM)) else $error("no switch to stream");

  chk_trig_buffer: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    (mode == grsf_pkg::GRSF_MODE_STR2BUF) && trigger_event && !wr_acc |=>
      (beh == grsf_pkg::GRSF_BEH_BUFFER)) else $error("no switch to buffer");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    irq == (|(evt_reg & evtmask_reg))) else $error("irq does not follow events");

  chk_pop_advance: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    seq_z_read |=> (cnt_reg == $past(cnt_reg) - CW'(1)) && (rd_reg == $past(rd_reg) + AW'(1)))
    else $error("pop did not advance");

  chk_burst_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    rd_acc && (paddr == `GRSF_OFF_BURST) && (burst_reg == 2'h2) |=> burst_reg == 2'h0)
    else $error("burst lane did not wrap");

  // burst lanes step x to y to z one read at a time
  chk_burst_step: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    rd_acc && (paddr == `GRSF_OFF_BURST) && (burst_reg != 2'h2) |=>
      burst_reg == $past(burst_reg) + 2'h1) else $error("burst lane did not step");

  // a new full level must survive a write-one-clear in the same cycle
  chk_full_event: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    lvl[`GRSF_EV_FULL] && !lvl_reg[`GRSF_EV_FULL] |=> evt_reg[`GRSF_EV_FULL])
    else $error("full event lost");

  // an empty buffer refuses pops
  chk_empty_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    empty && !push |=> empty) else $error("empty buffer popped");

  // buffer behaviour freezes the write pointer once full
  chk_buffer_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (beh == grsf_pkg::GRSF_BEH_BUFFER) && full && !pop |=> $stable(wr_reg))
    else $error("write pointer moved while full");

  // reading x alone must not consume the triplet
  chk_x_nopop: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    rd_acc && (paddr == `GRSF_OFF_OUTX) && !push && (beh != grsf_pkg::GRSF_BEH_BYPASS)
      |=> $stable(cnt_reg)) else $error("x read changed count");
endmodule // grsf_top
`default_nettype wire

/* File: tb/grsf_sensor_model.sv */
// sensor core model: emits one x/y/z triplet per cycle of push_req
// assumes: same clock as the buffer; values follow a fixed sequence
`timescale 1ns/1ps
`default_nettype none
module grsf_sensor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push_req,
  output logic sample_valid,
  output logic [15:0] sample_x,
  output logic [15:0] sample_y,
  output logic [15:0] sample_z
);
  logic [15:0] seq_reg; // index of next triplet

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle valid pulse per triplet; idle lines show inverted data, never stale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= 16'h0000;
      sample_valid <= 1'b0;
      sample_x <= 16'h0000;
      sample_y <= 16'h0000;
      sample_z <= 16'h0000;
    end else if (push_req) begin
      sample_valid <= 1'b1;
      sample_x <= seq_reg;
      sample_y <= seq_reg ^ 16'h5A5A;
      sample_z <= ~seq_reg;
      seq_reg <= seq_reg + 16'h0001;
    end else begin
      sample_valid <= 1'b0;
      sample_x <= ~sample_x;
      sample_y <= ~sample_y;
      sample_z <= ~sample_z;
    end
  end
endmodule // grsf_sensor_model
`default_nettype wire

/* File: tb/gyro_rate_sample_fifo_tb_top.sv */
// bench of the rate sample buffer: apb tasks, sample pushes, mode walk
// assumes: one wait state apb slave, samples from the sensor model
`timescale 1ns/1ps
`default_nettype none
module gyro_rate_sample_fifo_tb_top;
  logic pclk = 1'b0; // 10 mhz bus clock
  logic presetn = 1'b0; // held low for six cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic push_req = 1'b0; // request to the sensor model
  logic trigger_event = 1'b0; // event generator stand-in
  logic sample_valid;
  logic [15:0] sample_x, sample_y, sample_z;
  logic ready_event_pin, irq;
  int num_errors = 0;
  int total_checks = 0;
  int sent = 0; // triplets emitted so far
  int base = 0; // first triplet of the current mode
  logic [31:0] rdat;
  logic rerr;

  always #50 pclk = ~pclk;

  grsf_sensor_model u_sensor (.pclk(pclk), .presetn(presetn), .push_req(push_req),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z));

  grsf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .trigger_event(trigger_event),
    .ready_event_pin(ready_event_pin), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // expected sample words, upper half zero
  function automatic logic [31:0] ex(input int n);
    return {16'h0000, 16'(n)};
  endfunction
  function automatic logic [31:0] ey(input int n);
    return {16'h0000, 16'(n) ^ 16'h5A5A};
  endfunction
  function automatic logic [31:0] ez(input int n);
    return {16'h0000, ~16'(n)};
  endfunction

  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready_wait", 32'h1, 32'h0);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h00000000);
    chk(name, exp, rdat);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // n back-to-back triplets, then let status settle
  task automatic push(input int n);
    @(posedge pclk);
    push_req <= 1'b1;
    repeat (n) @(posedge pclk);
    push_req <= 1'b0;
    sent += n;
    repeat (3) @(posedge pclk);
  endtask

  task automatic trig();
    @(posedge pclk);
    trigger_event <= 1'b1;
    @(posedge pclk);
    trigger_event <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: whole run is a few hundred cycles
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h08, 32'h00000003, "status_reset");
    rd(8'h00, 32'h00000000, "ctrl_reset");
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    rd(8'h0C, 32'h00000003, "sticky_reset");
    wr(8'h0C, 32'h00000007);
    wr(8'h10, 32'h00000002);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // buffer mode, watermark 4: fill past full
    wr(8'h00, 32'h00000024);
    base = sent;
    push(33);
    rd(8'h08, 32'h00000105, "status_full");
    rd(8'h0C, 32'h00000005, "sticky_full");
    wr(8'h10, 32'h00000004);
    wr(8'h04, 32'h00000004);
    repeat (2) @(posedge pclk);
    chk("irq_full", 32'h1, {31'h0, irq});
    chk("pin_full", 32'h1, {31'h0, ready_event_pin});
    // the burst window stands in for the auto-increment sub-address
    rd(8'h20, ex(base), "burst_x");
    rd(8'h20, ey(base), "burst_y");
    rd(8'h20, ez(base), "burst_z");
    rd(8'h20, ex(base + 1), "burst_wrap");
    rd(8'h14, ex(base + 1), "single_x");
    rd(8'h18, ey(base + 1), "single_y");
    rd(8'h1C, ez(base + 1), "single_z");
    rd(8'h08, 32'h000000F1, "status_30");
    wr(8'h0C, 32'h00000007);
    repeat (2) @(posedge pclk);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    chk("pin_notfull", 32'h0, {31'h0, ready_event_pin});
    // bypass restarts and keeps only the live triplet
    wr(8'h00, 32'h00000000);
    rd(8'h08, 32'h00000003, "status_bypass");
    wr(8'h04, 32'h00000002);
    repeat (2) @(posedge pclk);
    chk("pin_empty", 32'h1, {31'h0, ready_event_pin});
    push(2);
    rd(8'h08, 32'h00000003, "bypass_empty");
    rd(8'h14, ex(sent - 1), "bypass_live");
    // stream: oldest two dropped
    wr(8'h00, 32'h00000040);
    base = sent;
    push(34);
    rd(8'h08, 32'h00000105, "stream_full");
    rd(8'h14, ex(base + 2), "stream_oldest");
    // bypass-to-stream
    wr(8'h00, 32'h00000060);
    push(3);
    rd(8'h08, 32'h00000003, "b2s_pre");
    trig();
    base = sent;
    push(2);
    rd(8'h08, 32'h00000011, "b2s_post");
    rd(8'h14, ex(base), "b2s_oldest");
    // stream-to-buffer: drops before trigger, holds after; the two triplets
    // left from bypass-to-stream make 36 arrivals, so base + 2 stays oldest
    wr(8'h00, 32'h00000080);
    base = sent;
    push(34);
    trig();
    push(5);
    rd(8'h08, 32'h00000105, "s2b_full");
    rd(8'h14, ex(base + 2), "s2b_oldest");
    // reset in mid-run empties a full buffer and clears the mode
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h08, 32'h00000003, "status_rereset");
    rd(8'h00, 32'h00000000, "ctrl_rereset");
    end_of_test();
  end
endmodule // gyro_rate_sample_fifo_tb_top
`default_nettype wire
